// ### common/scs_pkg.sv
// Constants, layouts and types of the start-up configuration sequencer
package scs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing, in microseconds
  localparam int SCS_CLK_MHZ          = 100;
  localparam int SCS_T_BACKUP_US      = 5000;
  localparam int SCS_T_BACKUP_LATE_US = 24000;
  localparam int SCS_T_RESET_US       = 2000;
  localparam int SCS_T_FIRST0_US      = 2000;
  localparam int SCS_T_FIRST1_US      = 2500;
  localparam int SCS_T_FIRST2_US      = 4000;
  localparam int SCS_T_FIRST3_US      = 7000;
  localparam int SCS_T_STEP0_US       = 500;
  localparam int SCS_T_STEP1_US       = 1000;
  localparam int SCS_T_STEP2_US       = 2000;
  localparam int SCS_T_STEP3_US       = 4000;
  localparam int SCS_CNT_W            = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Rails and the default set
  localparam int SCS_NUM_RAILS     = 8;
  localparam int SCS_SLOT_W        = 5;
  localparam int SCS_RAIL_BUCK1    = 0;
  localparam int SCS_RAIL_BUCK2    = 1;
  localparam int SCS_RAIL_BUCK3A   = 2;
  localparam int SCS_RAIL_BUCK3B   = 3;
  localparam int SCS_RAIL_BOOST    = 4;
  localparam int SCS_RAIL_MEMREF   = 5;
  localparam int SCS_RAIL_LDO2     = 6;
  localparam int SCS_RAIL_LDO4     = 7;
  localparam logic [SCS_NUM_RAILS-1:0][SCS_SLOT_W-1:0] SCS_DFLT_SLOTS =
    {5'h03, 5'h02, 5'h03, 5'h00, 5'h03, 5'h03, 5'h02, 5'h01};
  localparam logic [1:0] SCS_DFLT_STEP    = 2'h1;
  localparam logic [1:0] SCS_RAMP_6P25    = 2'h1;
  localparam logic [2:0] SCS_DFLT_ADDR_LO = 3'h0;
  localparam logic [3:0] SCS_ADDR_HI      = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Fuse words: one per rail, then one general word
  localparam int         SCS_MEM_DW     = 16;
  localparam int         SCS_MEM_AW     = 4;
  localparam logic [3:0] SCS_GEN_IDX    = 4'h8;
  localparam logic [3:0] SCS_LD_LAST    = 4'h9;
  localparam int         SCS_GEN_STEP_P = 0;
  localparam int         SCS_GEN_RAMP_P = 2;
  localparam int         SCS_GEN_PG_P   = 4;
  localparam int         SCS_GEN_TRIG_P = 5;
  localparam int         SCS_GEN_ADDR_P = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int          SCS_AW         = 12;
  localparam logic [11:0] SCS_OFF_STATUS = 12'h000;
  localparam logic [11:0] SCS_OFF_PROG   = 12'h004;
  localparam logic [11:0] SCS_OFF_CONFIG = 12'h008;
  localparam logic [11:0] SCS_OFF_ENABLE = 12'h00C;
  localparam logic [11:0] SCS_OFF_FUSE0  = 12'h040;
  localparam logic [11:0] SCS_OFF_FUSEL  = 12'h060;
  localparam int          SCS_ST_SRC_P   = 9;
  localparam int          SCS_ST_PROG_P  = 10;
  localparam int          SCS_ST_RST_P   = 11;
  localparam int          SCS_ST_BKUP_P  = 12;
  localparam int          SCS_ST_COIN_P  = 13;
  localparam int          SCS_ST_SLOT_P  = 16;
  localparam int          SCS_CF_ADDR_P  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [8:0] {
    SCS_ST_OFF   = 9'h001,
    SCS_ST_BKUP  = 9'h002,
    SCS_ST_LOAD  = 9'h004,
    SCS_ST_HALT  = 9'h008,
    SCS_ST_IDLE  = 9'h010,
    SCS_ST_FIRST = 9'h020,
    SCS_ST_STEP  = 9'h040,
    SCS_ST_RSTW  = 9'h080,
    SCS_ST_RUN   = 9'h100
  } scs_state_t;

endpackage

// ### src/scs_cfg_mem.sv
// Small fuse-image memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module scs_cfg_mem #(
  parameter int DW    = 16,
  parameter int AW    = 4,
  parameter int DEPTH = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem_q [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Array has no reset, like real fuse storage it is written before use
  always_ff @(posedge pclk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  // Read-before-write on the same address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[addr];
    end
  end

endmodule
`default_nettype wire

// ### src/scs_sequencer.sv
// Start-up configuration sequencer with APB register port
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer #(
  parameter int CYC_PER_US = scs_pkg::SCS_CLK_MHZ
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic [scs_pkg::SCS_AW-1:0]         paddr,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               config_source_strap,
  input  wire logic                               main_supply_input,
  input  wire logic                               coin_cell_input,
  input  wire logic                               power_on_input,
  output logic      [scs_pkg::SCS_NUM_RAILS-1:0]  rail_en,
  output logic                                    backup_rail_en,
  output logic                                    host_reset_out_o,
  output logic                                    host_reset_out_oe,
  output logic      [6:0]                         slave_addr,
  output logic      [1:0]                         voltage_ramp_rate,
  output logic                                    power_good_mode
);
  import scs_pkg::*;

  localparam int NR = SCS_NUM_RAILS;
  localparam int CW = SCS_CNT_W;
  typedef logic [NR-1:0][SCS_SLOT_W-1:0] scs_slots_t;

  scs_state_t            st_q, st_d;
  logic [CW-1:0]         cnt_q, cnt_d;
  logic [SCS_SLOT_W-1:0] cur_q, cur_d;
  logic [3:0]            sync1_q, sync2_q;
  logic                  strap_s, main_s, coin_s, pwr_s;
  logic                  src_dflt_q, coin_early_q, prog_q;
  logic [3:0]            ld_idx_q;
  scs_slots_t            slot_q;
  logic [1:0]            step_q, ramp_q;
  logic                  pg_q, trig_q;
  logic [2:0]            addr_lo_q;
  logic [NR-1:0]         rail_en_q;
  logic                  bkup_q, rst_q;
  logic [1:0]            rd_ph_q;
  logic [31:0]           prdata_q, rd_mux;
  logic                  acc, fuse_hit, mapped, mem_busy, mem_we;
  logic [SCS_MEM_AW-1:0] mem_addr;
  logic [SCS_MEM_DW-1:0] mem_rdata;
  logic                  seq_on;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts from microseconds, minus one for a down-counter to zero
  function automatic logic [CW-1:0] us_cyc(input int us);
    return CW'(us * CYC_PER_US - 1);
  endfunction

  function automatic logic [CW-1:0] first_cyc(input logic [1:0] code);
    unique case (code)
      2'h0:    return us_cyc(SCS_T_FIRST0_US);
      2'h1:    return us_cyc(SCS_T_FIRST1_US);
      2'h2:    return us_cyc(SCS_T_FIRST2_US);
      default: return us_cyc(SCS_T_FIRST3_US);
    endcase
  endfunction

  function automatic logic [CW-1:0] step_cyc(input logic [1:0] code);
    unique case (code)
      2'h0:    return us_cyc(SCS_T_STEP0_US);
      2'h1:    return us_cyc(SCS_T_STEP1_US);
      2'h2:    return us_cyc(SCS_T_STEP2_US);
      default: return us_cyc(SCS_T_STEP3_US);
    endcase
  endfunction

  // Highest programmed slot ends the sequence
  function automatic logic [SCS_SLOT_W-1:0] max_slot(input scs_slots_t s);
    logic [SCS_SLOT_W-1:0] m;
    m = '0;
    for (int i = 0; i < NR; i++) begin
      if (s[i] > m) begin
        m = s[i];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {power_on_input, coin_cell_input, main_supply_input, config_source_strap};
      sync2_q <= sync1_q;
    end
  end
  assign strap_s = sync2_q[0];
  assign main_s  = sync2_q[1];
  assign coin_s  = sync2_q[2];
  assign pwr_s   = sync2_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // Next state; supply loss overrides everything
  always_comb begin
    st_d  = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    cur_d = cur_q;
    if (!main_s) begin
      st_d  = SCS_ST_OFF;
      cnt_d = '0;
      cur_d = '0;
    end else begin
      unique case (st_q)
        SCS_ST_OFF: begin
          st_d  = SCS_ST_BKUP;
          cnt_d = coin_s ? us_cyc(SCS_T_BACKUP_US) : us_cyc(SCS_T_BACKUP_LATE_US);
        end
        SCS_ST_BKUP: begin
          if (cnt_q == '0) begin
            st_d = SCS_ST_LOAD;
          end
        end
        SCS_ST_LOAD: begin
          if (src_dflt_q) begin
            st_d = SCS_ST_IDLE;
          end else if (!prog_q) begin
            st_d = SCS_ST_HALT;
          end else if (ld_idx_q == SCS_LD_LAST) begin
            st_d = SCS_ST_IDLE;
          end
        end
        SCS_ST_HALT: begin
          if (prog_q) begin
            st_d = SCS_ST_LOAD;
          end
        end
        SCS_ST_IDLE: begin
          if (pwr_s) begin
            st_d  = SCS_ST_FIRST;
            cnt_d = first_cyc(step_q);
            cur_d = '0;
          end
        end
        SCS_ST_FIRST, SCS_ST_STEP, SCS_ST_RSTW, SCS_ST_RUN: begin
          if (!pwr_s) begin
            st_d  = SCS_ST_IDLE;
            cnt_d = '0;
            cur_d = '0;
          end else if (st_q == SCS_ST_FIRST) begin
            if (cnt_q == '0) begin
              st_d  = SCS_ST_STEP;
              cur_d = 5'h01;
              cnt_d = step_cyc(step_q);
            end
          end else if (st_q == SCS_ST_STEP) begin
            if (cur_q >= max_slot(slot_q)) begin
              st_d  = SCS_ST_RSTW;
              cnt_d = us_cyc(SCS_T_RESET_US);
            end else if (cnt_q == '0) begin
              cur_d = cur_q + 1'b1;
              cnt_d = step_cyc(step_q);
            end
          end else if (st_q == SCS_ST_RSTW) begin
            if (cnt_q == '0) begin
              st_d = SCS_ST_RUN;
            end
          end
        end
        default: st_d = SCS_ST_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= SCS_ST_OFF;
      cnt_q <= '0;
      cur_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      cur_q <= cur_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap and coin cell caught once per supply power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_dflt_q   <= 1'b0;
      coin_early_q <= 1'b0;
    end else if (st_q == SCS_ST_OFF && main_s) begin
      src_dflt_q   <= strap_s;
      coin_early_q <= coin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration load: default set in one cycle, fuses word by word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_idx_q  <= 4'h0;
      slot_q    <= '0;
      step_q    <= SCS_DFLT_STEP;
      ramp_q    <= SCS_RAMP_6P25;
      pg_q      <= 1'b0;
      trig_q    <= 1'b0;
      addr_lo_q <= SCS_DFLT_ADDR_LO;
    end else begin
      ld_idx_q <= (st_q == SCS_ST_LOAD && !src_dflt_q && prog_q) ? ld_idx_q + 1'b1 : 4'h0;
      if (st_q == SCS_ST_LOAD && src_dflt_q) begin
        slot_q    <= SCS_DFLT_SLOTS;
        step_q    <= SCS_DFLT_STEP;
        ramp_q    <= SCS_RAMP_6P25;
        pg_q      <= 1'b0;
        trig_q    <= 1'b0;
        addr_lo_q <= SCS_DFLT_ADDR_LO;
      end else if (st_q == SCS_ST_LOAD && prog_q && ld_idx_q != 4'h0) begin
        // Read data lags the address by one cycle
        if (ld_idx_q - 1'b1 == SCS_GEN_IDX) begin
          step_q    <= mem_rdata[SCS_GEN_STEP_P +: 2];
          ramp_q    <= mem_rdata[SCS_GEN_RAMP_P +: 2];
          pg_q      <= mem_rdata[SCS_GEN_PG_P];
          trig_q    <= mem_rdata[SCS_GEN_TRIG_P];
          addr_lo_q <= mem_rdata[SCS_GEN_ADDR_P +: 3];
        end else begin
          slot_q[3'(ld_idx_q - 1'b1)] <= mem_rdata[SCS_SLOT_W-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail enables, backup rail and host reset
  assign seq_on = (st_q == SCS_ST_STEP) || (st_q == SCS_ST_RSTW) || (st_q == SCS_ST_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rail_en_q <= '0;
    end else begin
      for (int i = 0; i < NR; i++) begin
        rail_en_q[i] <= seq_on && pwr_s && main_s && slot_q[i] != '0 && slot_q[i] <= cur_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bkup_q <= 1'b0;
    end else if (!main_s) begin
      bkup_q <= 1'b0;
    end else if (st_q == SCS_ST_BKUP && cnt_q == '0) begin
      bkup_q <= 1'b1;
    end
  end

  // Released only on entry to the run state; any turn-off reasserts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= (st_d != SCS_ST_RUN);
    end
  end

  assign rail_en           = rail_en_q;
  assign backup_rail_en    = bkup_q;
  assign host_reset_out_o  = 1'b0;
  assign host_reset_out_oe = rst_q;
  assign slave_addr        = {SCS_ADDR_HI, addr_lo_q};
  assign voltage_ramp_rate = ramp_q;
  assign power_good_mode   = pg_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave; works in every state, fuse window stalls only during load
  assign acc      = psel && penable;
  assign fuse_hit = (paddr >= SCS_OFF_FUSE0) && (paddr <= SCS_OFF_FUSEL) && (paddr[1:0] == 2'h0);
  assign mapped   = fuse_hit || paddr == SCS_OFF_STATUS || paddr == SCS_OFF_PROG ||
                    paddr == SCS_OFF_CONFIG || paddr == SCS_OFF_ENABLE;
  assign mem_busy = (st_q == SCS_ST_LOAD);
  assign pready   = pwrite ? !(fuse_hit && mem_busy) : (rd_ph_q == 2'h2);
  assign pslverr  = acc && pready && !mapped;
  assign prdata   = prdata_q;
  // Fuses freeze once marked programmed
  assign mem_we   = acc && pwrite && fuse_hit && !mem_busy && !prog_q;
  assign mem_addr = mem_busy ? ld_idx_q : paddr[5:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (fuse_hit) begin
      rd_mux[SCS_MEM_DW-1:0] = mem_rdata;
    end else if (paddr == SCS_OFF_STATUS) begin
      rd_mux[8:0]                         = st_q;
      rd_mux[SCS_ST_SRC_P]                = src_dflt_q;
      rd_mux[SCS_ST_PROG_P]               = prog_q;
      rd_mux[SCS_ST_RST_P]                = rst_q;
      rd_mux[SCS_ST_BKUP_P]               = bkup_q;
      rd_mux[SCS_ST_COIN_P]               = coin_early_q;
      rd_mux[SCS_ST_SLOT_P +: SCS_SLOT_W] = cur_q;
    end else if (paddr == SCS_OFF_PROG) begin
      rd_mux[0] = prog_q;
    end else if (paddr == SCS_OFF_CONFIG) begin
      rd_mux[SCS_GEN_STEP_P +: 2] = step_q;
      rd_mux[SCS_GEN_RAMP_P +: 2] = ramp_q;
      rd_mux[SCS_GEN_PG_P]        = pg_q;
      rd_mux[SCS_GEN_TRIG_P]      = trig_q;
      rd_mux[SCS_CF_ADDR_P +: 7]  = slave_addr;
    end else if (paddr == SCS_OFF_ENABLE) begin
      rd_mux[NR-1:0] = rail_en_q;
    end
  end

  // Reads take two wait cycles so read data leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ph_q  <= 2'h0;
      prdata_q <= 32'h0000_0000;
    end else if (acc && !pwrite) begin
      unique case (rd_ph_q)
        2'h0:    rd_ph_q <= (fuse_hit && mem_busy) ? 2'h0 : 2'h1;
        2'h1: begin
          rd_ph_q  <= 2'h2;
          prdata_q <= rd_mux;
        end
        default: rd_ph_q <= 2'h0;
      endcase
    end else begin
      rd_ph_q <= 2'h0;
    end
  end

  // Programmed mark is one-time: only hardware reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_q <= 1'b0;
    end else if (acc && pwrite && paddr == SCS_OFF_PROG && pwdata[0]) begin
      prog_q <= 1'b1;
    end
  end

  scs_cfg_mem #(
    .DW    (SCS_MEM_DW),
    .AW    (SCS_MEM_AW),
    .DEPTH (16)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (pwdata[SCS_MEM_DW-1:0]),
    .rdata_q (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Rails placed exactly at slot n, kept apart from the enable logic on purpose
  function automatic logic [NR-1:0] at_slot(input scs_slots_t s, input logic [SCS_SLOT_W-1:0] n);
    logic [NR-1:0] r;
    r = '0;
    for (int i = 0; i < NR; i++) begin
      r[i] = (s[i] == n);
    end
    return r;
  endfunction

  sequence s_first_done;
    st_q == SCS_ST_FIRST && cnt_q == '0 && pwr_s && main_s;
  endsequence
  sequence s_first_slot;
    st_q == SCS_ST_STEP && cur_q == 5'h01;
  endsequence

  property p_halt_dark;
    @(posedge pclk) disable iff (!presetn) st_q == SCS_ST_HALT |-> rail_en_q == '0 && rst_q;
  endproperty
  a_halt_dark: assert property (p_halt_dark) else $error("rails on while halted");

  property p_halt_bus;
    @(posedge pclk) disable iff (!presetn) st_q == SCS_ST_HALT && acc && pwrite |-> pready;
  endproperty
  a_halt_bus: assert property (p_halt_bus) else $error("bus stalled while halted");

  property p_default_set;
    @(posedge pclk) disable iff (!presetn)
      st_q == SCS_ST_LOAD && src_dflt_q && main_s |=> slot_q == SCS_DFLT_SLOTS && step_q == SCS_DFLT_STEP
      && ramp_q == SCS_RAMP_6P25 && slave_addr == 7'h08 && !pg_q;
  endproperty
  a_default_set: assert property (p_default_set) else $error("default set wrong");

  property p_first_slot;
    @(posedge pclk) disable iff (!presetn)
      s_first_done |=> s_first_slot ##1 rail_en_q == ($past(pwr_s && main_s) ? at_slot(slot_q, 5'h01) : '0);
  endproperty
  a_first_slot: assert property (p_first_slot) else $error("first slot not reached");

  property p_first_delay;
    @(posedge pclk) disable iff (!presetn)
      st_q == SCS_ST_IDLE && pwr_s && main_s |=> st_q == SCS_ST_FIRST && cnt_q == first_cyc(step_q);
  endproperty
  a_first_delay: assert property (p_first_delay) else $error("first delay count wrong");

  property p_step_reload;
    @(posedge pclk) disable iff (!presetn)
      st_q == SCS_ST_STEP && pwr_s && main_s && cnt_q == '0 && cur_q < max_slot(slot_q)
      |=> cnt_q == step_cyc(step_q) && cur_q == $past(cur_q) + 5'h01;
  endproperty
  a_step_reload: assert property (p_step_reload) else $error("slot step wrong");

  property p_reset_release;
    @(posedge pclk) disable iff (!presetn) $fell(rst_q) |-> $past(st_q == SCS_ST_RSTW && cnt_q == '0);
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("host reset released early");

  property p_turn_off;
    @(posedge pclk) disable iff (!presetn)
      st_q == SCS_ST_RUN && !pwr_s && main_s |=> st_q == SCS_ST_IDLE && rst_q ##1 rail_en_q == '0;
  endproperty
  a_turn_off: assert property (p_turn_off) else $error("turn-off not honoured");

  property p_hold_en;
    @(posedge pclk) disable iff (!presetn)
      seq_on && pwr_s && main_s && $past(seq_on) |-> (rail_en_q & $past(rail_en_q)) == $past(rail_en_q);
  endproperty
  a_hold_en: assert property (p_hold_en) else $error("rail enable dropped");

  property p_backup;
    @(posedge pclk) disable iff (!presetn) $rose(bkup_q) |-> $past(st_q == SCS_ST_BKUP && cnt_q == '0);
  endproperty
  a_backup: assert property (p_backup) else $error("backup rail timing wrong");

  property p_strap_once;
    @(posedge pclk) disable iff (!presetn) st_q != SCS_ST_OFF && $past(st_q != SCS_ST_OFF) |-> $stable(src_dflt_q);
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("strap relatched");

endmodule
`default_nettype wire

// ### dv/scs_host.sv
// Host model: pulled-up reset pin seen by the processor
`timescale 1ns/1ps
`default_nettype none
module scs_host (
  input  wire logic host_reset_out_o,
  input  wire logic host_reset_out_oe,
  output logic      reset_line
);
  // Pull-up wins unless the device pulls low
  assign reset_line = host_reset_out_oe ? host_reset_out_o : 1'b1;
endmodule
`default_nettype wire

// ### dv/scs_sequencer_bench.sv
// Self-checking bench of the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_bench;
  import scs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, strap = 1, main_in = 0, coin = 1, pwr_on = 0;
  logic [7:0]  rail_en;
  logic        bk_en, rst_o, rst_oe, pg, line;
  logic [6:0]  saddr;
  logic [1:0]  ramp, st, rm;
  logic [2:0]  lo3;
  logic [4:0]  sl [8];
  int          cyc = 0, mismatches = 0, check_count = 0, t0, t_bk, t_rst, t_on [8];

  scs_sequencer #(.CYC_PER_US(1)) scs_sequencer_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .config_source_strap(strap), .main_supply_input(main_in), .coin_cell_input(coin),
    .power_on_input(pwr_on), .rail_en(rail_en), .backup_rail_en(bk_en), .host_reset_out_o(rst_o),
    .host_reset_out_oe(rst_oe), .slave_addr(saddr), .voltage_ramp_rate(ramp), .power_good_mode(pg));
  scs_host scs_host_i (.host_reset_out_o(rst_o), .host_reset_out_oe(rst_oe), .reset_line(line));

  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  // Stamp first rise of each enable, backup and reset release
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 8; i++) if (rail_en[i] === 1'b1 && t_on[i] < 0) t_on[i] = cyc;
    if (bk_en === 1'b1 && t_bk < 0) t_bk = cyc;
    if (line === 1'b1 && t_rst < 0) t_rst = cyc;
    if (cyc == 90000) begin
      mismatches++;
      give_verdict();
    end
  end

  function automatic bit near(int a, int b);
    return a - b <= 8 && b - a <= 8;
  endfunction

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Held until pready; a spare edge keeps calls from colliding
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    chk("apb answer", 1, n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic wait_for(ref int t);
    for (int n = 0; n < 40000 && t < 0; n++) @(posedge pclk);
  endtask

  // Slot n comes at first delay plus n-1 steps
  task automatic chk_seq(int r, logic [1:0] c, logic [4:0] s [8]);
    int hi, f, d;
    logic [7:0] m;
    hi = 0;
    f = c == 0 ? 2000 : c == 1 ? 2500 : c == 2 ? 4000 : 7000;
    d = 500 << c;
    for (int i = 0; i < 8; i++) begin
      m[i] = s[i] != 0;
      if (s[i] > hi) hi = s[i];
      chk("enable time", 1, s[i] ? near(t_on[i], r + f + (s[i] - 1) * d) : t_on[i] < 0);
    end
    chk("reset release", 1, near(t_rst, r + f + (hi - 1) * d + 2000));
    chk("enables held", m, rail_en);
  endtask

  task automatic start();
    t_bk = -1;
    t_rst = -1;
    foreach (t_on[i]) t_on[i] = -1;
    main_in <= 1;
    pwr_on <= 1;
    t0 = cyc;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hB10DDE93));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    // Default set; strap moved late must not matter
    start();
    repeat (100) @(posedge pclk);
    strap <= 0;
    wait_for(t_rst);
    chk("backup delay", 1, near(t_bk, t0 + 5000));
    foreach (sl[i]) sl[i] = SCS_DFLT_SLOTS[i];
    chk_seq(t_bk, SCS_DFLT_STEP, sl);
    chk("address", 7'h08, saddr);
    chk("ramp", SCS_RAMP_6P25, ramp);
    chk("pg mode", 0, pg);
    pwr_on <= 0;
    repeat (6) @(posedge pclk);
    chk("rails off", 0, rail_en);
    chk("reset again", 0, line);
    $display("test default set done");
    // Unprogrammed fuses, late coin cell
    presetn <= 0;
    main_in <= 0;
    coin <= 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    start();
    wait_for(t_bk);
    chk("late backup", 1, near(t_bk, t0 + 24000));
    repeat (50) @(posedge pclk);
    chk("no rails", 0, rail_en);
    apb(0, SCS_OFF_STATUS, 0);
    chk("halt state", SCS_ST_HALT, rd[8:0]);
    apb(0, 12'hFF0, 0);
    chk("unmapped", 1, err);
    for (int i = 0; i < 8; i++) begin
      sl[i] = 5'($urandom_range(4, 1));
      apb(1, SCS_OFF_FUSE0 + 12'(4 * i), {27'h0, sl[i]});
    end
    st = 2'($urandom_range(3, 0));
    lo3 = 3'($urandom_range(7, 0));
    rm = 2'($urandom_range(3, 0));
    apb(1, SCS_OFF_FUSEL, {23'h0, lo3, 2'h0, rm, st});
    apb(1, SCS_OFF_PROG, 32'h1);
    t0 = cyc;
    wait_for(t_rst);
    chk_seq(t0 + 10, st, sl);
    chk("fuse address", {4'h1, lo3}, saddr);
    chk("fuse ramp", rm, ramp);
    apb(0, SCS_OFF_CONFIG, 0);
    chk("config read", {19'h0, 4'h1, lo3, 2'h0, rm, st}, rd);
    $display("test fuse set done");
    give_verdict();
  end
endmodule
`default_nettype wire
